// ---- hdl/ifp_pkg.sv ----
/*
  Constants, opcode patterns and types for the instruction fetch pipeline.
  Assumes a 16-bit wide program memory port and an 8-bit data memory.
*/
`default_nettype none
package ifp_pkg;
  localparam int PC_W = 21;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int DM_AW = 12;
  localparam int STACK_DEPTH = 31;
  localparam int SP_W = 5;
  localparam int TP_BYTES = 3;

  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [WORD_W-1:0] IR_RESET = 16'h0000;
  localparam logic [SP_W-1:0] SP_RESET = 5'h00;
  localparam logic [3:0] PHASE_RESET = 4'h1;

  // one-hot phase positions
  localparam int PH1 = 0;
  localparam int PH2 = 1;
  localparam int PH3 = 2;
  localparam int PH4 = 3;

  // opcode patterns
  localparam logic [3:0] OPC_SECOND_NIB = 4'hf;
  localparam logic [3:0] OPC_MOVE_FILE_TO_FILE_NIB = 4'hc;
  localparam logic [7:0] OPC_MOVE_LITERAL_TO_WORKING_HI = 8'h0f;
  localparam logic [7:0] OPC_GOTO_HI = 8'hef;
  localparam logic [7:0] OPC_CALL_HI = 8'hec;
  localparam logic [7:0] OPC_RETURN_WITH_LITERAL_HI = 8'h0c;
  localparam logic [6:0] OPC_TEST_SKIP_IF_ZERO_HI = 7'h33;
  localparam logic [5:0] OPC_ADD_WORKING_TO_FILE_HI = 6'h09;
  localparam logic [4:0] OPC_BRA_HI = 5'h1a;
  localparam logic [WORD_W-1:0] OPC_RETURN = 16'h0012;
  localparam logic [WORD_W-1:0] OPC_TBLRD = 16'h0008;

  // instruction fields
  localparam int DEST_BIT = 9;
  localparam int BRA_OFF_W = 11;
  localparam int LIT12_W = 12;

  // data memory map
  localparam logic [DM_AW-1:0] ADDR_PCL = 12'hff9;
  localparam logic [DM_AW-1:0] ADDR_TABLE_POINTER = 12'hff6;
  localparam logic [BYTE_W-1:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

  typedef enum logic [3:0] {
    op_nop = 4'b0000,
    op_move_literal_to_working = 4'b0001,
    op_add_working_to_file = 4'b0010,
    op_test_skip_if_zero = 4'b0011,
    op_move_file_to_file = 4'b0100,
    op_goto = 4'b0101,
    op_call = 4'b0110,
    op_return = 4'b0111,
    op_return_with_literal = 4'b1000,
    op_bra = 4'b1001,
    op_tblrd = 4'b1010,
    op_second = 4'b1011
  } ifp_op_t;
endpackage
`default_nettype wire

// ---- hdl/ifp_core.sv ----
/*
  Fetch and execute sequencer of a small 8-bit core: phase divider,
  program counter, prefetch with flush, two-word handling, return stack,
  table read and data memory operand/destination strobes.
  Assumes both memories answer combinationally in the cycle of the address.
*/
// How it works
// RULE_01 - clock divided by four into one-hot phases one to four
// RULE_02 - counter steps in phase one, fetched word latched in phase four
// RULE_03 - fetched word executes during the following instruction cycle
// RULE_04 - prefetch moves into instruction latch at phase one, then executes
// RULE_05 - fetch of next word overlaps execution of current word
// RULE_06 - flow changes discard the prefetched word, giving one bubble
// RULE_07 - operand read in phase two, destination write in phase four
// RULE_08 - byte-addressed program memory, words on even addresses
// RULE_09 - counter steps by two and its low bit is always zero
// RULE_10 - absolute targets are word addresses loaded into bits 20:1
// RULE_11 - relative branch offsets count words, not bytes
// RULE_12 - second words carry 1111 on top and 12 literal bits
// RULE_13 - second word after its first supplies the literal bits
// RULE_14 - lone second word executes as a no-operation
// RULE_15 - software adds only even offsets to the counter low byte
// RULE_16 - return with literal returns and loads working register
// RULE_17 - table read takes one byte addressed by table pointer
// RULE_18 - after reset prefetch is empty so first cycle only fetches
// RULE_19 - call increments stack pointer then stores the advanced counter
`timescale 1ns/1ns
`default_nettype none
module ifp_core #(
  parameter int STACK_DEPTH = ifp_pkg::STACK_DEPTH
) (
  input wire logic i_clk, // core clock
  input wire logic i_reset_n, // async reset, low active
  input wire logic [15:0] i_pm_data, // program memory word
  input wire logic [7:0] i_dm_rdata, // data memory read byte
  output logic [20:0] o_pm_addr, // program memory byte address
  output logic o_pm_rd, // program memory read strobe
  output logic [11:0] o_dm_addr, // data memory address
  output logic o_dm_rd, // operand read strobe
  output logic o_dm_wr, // destination write strobe
  output logic [7:0] o_dm_wdata, // destination write data
  output logic [3:0] o_phase, // one-hot phase, bit 0 = phase one
  output logic [20:0] o_pc, // program counter
  output logic [15:0] o_instruction_latch, // word being executed
  output logic [7:0] o_working_register, // working register
  output logic [7:0] o_table_data_latch, // last table read byte
  output logic [4:0] o_stack_pointer // return stack pointer
);

  logic [3:0] phase;
  logic [20:0] pc;
  logic [20:0] fetch_addr;
  logic [15:0] prefetch;
  logic prefetch_valid;
  logic [15:0] ir;
  logic second_due;
  ifp_pkg::ifp_op_t first_op;
  logic [7:0] first_lo;
  logic [7:0] working;
  logic [7:0] operand;
  logic [7:0] table_data;
  logic [23:0] table_pointer;
  logic [4:0] sp;
  logic [20:0] stack_mem [1:STACK_DEPTH];
  logic [20:0] pm_addr;
  logic [11:0] dm_addr;
  logic dm_wr;
  logic [7:0] dm_wdata;

  function automatic logic [11:0] access_addr(input logic [7:0] f);
    logic [11:0] a;
    a = {ifp_pkg::ACCESS_HI_BANK, f};
    if (f < ifp_pkg::ACCESS_SPLIT) begin
      a = {ifp_pkg::ACCESS_LO_BANK, f};
    end
    return a;
  endfunction

  function automatic ifp_pkg::ifp_op_t op_of(input logic [15:0] w,
                                             input logic due);
    ifp_pkg::ifp_op_t op;
    // unknown words execute as no-operation
    op = ifp_pkg::op_nop;
    if (w[15:12] == ifp_pkg::OPC_SECOND_NIB) begin
      op = due ? ifp_pkg::op_second : ifp_pkg::op_nop; // [RULE_13] [RULE_14]
    end else if (w[15:12] == ifp_pkg::OPC_MOVE_FILE_TO_FILE_NIB) begin
      op = ifp_pkg::op_move_file_to_file;
    end else if (w[15:8] == ifp_pkg::OPC_MOVE_LITERAL_TO_WORKING_HI) begin
      op = ifp_pkg::op_move_literal_to_working;
    end else if (w[15:8] == ifp_pkg::OPC_GOTO_HI) begin
      op = ifp_pkg::op_goto;
    end else if (w[15:8] == ifp_pkg::OPC_CALL_HI) begin
      op = ifp_pkg::op_call;
    end else if (w[15:8] == ifp_pkg::OPC_RETURN_WITH_LITERAL_HI) begin
      op = ifp_pkg::op_return_with_literal;
    end else if (w[15:9] == ifp_pkg::OPC_TEST_SKIP_IF_ZERO_HI) begin
      op = ifp_pkg::op_test_skip_if_zero;
    end else if (w[15:10] == ifp_pkg::OPC_ADD_WORKING_TO_FILE_HI) begin
      op = ifp_pkg::op_add_working_to_file;
    end else if (w[15:11] == ifp_pkg::OPC_BRA_HI) begin
      op = ifp_pkg::op_bra;
    end else if (w == ifp_pkg::OPC_RETURN) begin
      op = ifp_pkg::op_return;
    end else if (w == ifp_pkg::OPC_TBLRD) begin
      op = ifp_pkg::op_tblrd;
    end
    return op;
  endfunction

  // phase decode
  wire phase_one = phase[ifp_pkg::PH1];
  wire phase_two = phase[ifp_pkg::PH2];
  wire phase_three = phase[ifp_pkg::PH3];
  wire phase_four = phase[ifp_pkg::PH4];

  // bubble when the prefetch was flushed or never filled
  wire [15:0] next_ir = prefetch_valid ? prefetch : ifp_pkg::IR_RESET;
  wire ifp_pkg::ifp_op_t next_op = op_of(next_ir, second_due);
  wire ifp_pkg::ifp_op_t op = op_of(ir, second_due);

  wire is_second = (op == ifp_pkg::op_second);
  wire sec_goto = is_second && (first_op == ifp_pkg::op_goto);
  wire sec_call = is_second && (first_op == ifp_pkg::op_call);
  wire sec_move_file_to_file = is_second && (first_op == ifp_pkg::op_move_file_to_file);
  wire two_word_first = (op == ifp_pkg::op_goto) ||
                        (op == ifp_pkg::op_call) ||
                        (op == ifp_pkg::op_move_file_to_file);
  wire dest_file = ir[ifp_pkg::DEST_BIT];
  wire is_add_working_to_file = (op == ifp_pkg::op_add_working_to_file);
  wire is_tblrd = (op == ifp_pkg::op_tblrd);
  wire is_ret = (op == ifp_pkg::op_return) || (op == ifp_pkg::op_return_with_literal);
  wire is_bra = (op == ifp_pkg::op_bra);
  wire next_tblrd = (next_op == ifp_pkg::op_tblrd);

  wire reads_dm = is_add_working_to_file || (op == ifp_pkg::op_test_skip_if_zero) ||
                  (op == ifp_pkg::op_move_file_to_file);
  wire writes_dm = (is_add_working_to_file && dest_file) || sec_move_file_to_file;
  wire [7:0] sum = working + operand;

  // next data address, taken from the word entering the latch
  wire [11:0] next_dm_addr =
    (next_op == ifp_pkg::op_second || next_op == ifp_pkg::op_move_file_to_file) ?
    next_ir[ifp_pkg::LIT12_W-1:0] : access_addr(next_ir[7:0]); // [RULE_13]

  // flow change targets
  // fetch_addr holds the word after the one executing; pc is already
  // one word further, so it serves neither as return address nor as
  // base of relative and low byte jumps
  wire [20:0] ret_addr = fetch_addr; // [RULE_19]
  wire [20:0] abs_target = {ir[ifp_pkg::LIT12_W-1:0], first_lo,
                            1'b0}; // [RULE_10]
  // word offset, so shifted up one bit
  wire [20:0] bra_offset = {{(21-ifp_pkg::BRA_OFF_W-1)
                             {ir[ifp_pkg::BRA_OFF_W-1]}},
                            ir[ifp_pkg::BRA_OFF_W-1:0], 1'b0}; // [RULE_11]
  wire [20:0] bra_target = ret_addr + bra_offset; // [RULE_11]
  // empty stack pops the reset vector
  wire [20:0] pop_target = (sp == ifp_pkg::SP_RESET) ?
                           ifp_pkg::PC_RESET : stack_mem[sp];
  // low byte write is a jump; odd bit dropped
  wire pcl_wr = dm_wr && (dm_addr == ifp_pkg::ADDR_PCL);
  wire [20:0] pcl_target = {ret_addr[20:8], dm_wdata[7:1],
                            1'b0}; // [RULE_09]
  // skip cancels the prefetched word like a flush
  wire skip = (op == ifp_pkg::op_test_skip_if_zero) && (operand == 8'h00);
  // full stack ignores further pushes
  wire can_push = (sp != 5'(STACK_DEPTH));

  wire redirect = sec_goto || sec_call || is_ret || is_bra ||
                  pcl_wr; // [RULE_06]
  wire [20:0] jump_target = (sec_goto || sec_call) ? abs_target :
                            is_ret ? pop_target :
                            is_bra ? bra_target : pcl_target;

  // four-phase divider
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase <= ifp_pkg::PHASE_RESET;
    end else begin
      phase <= {phase[2:0], phase[3]}; // [RULE_01]
    end
  end

  // program counter
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pc <= ifp_pkg::PC_RESET;
      fetch_addr <= ifp_pkg::PC_RESET;
    end else if (phase_one) begin
      fetch_addr <= pc;
      pc <= pc + ifp_pkg::PC_STEP; // [RULE_02] [RULE_09]
    end else if (phase_four && redirect) begin
      pc <= jump_target; // [RULE_06] [RULE_10] [RULE_11]
    end
  end

  // fetch and prefetch
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prefetch <= ifp_pkg::IR_RESET;
      prefetch_valid <= 1'b0; // [RULE_18]
    end else if (phase_four) begin
      prefetch <= i_pm_data; // [RULE_02] [RULE_05]
      // flushed or skipped word stays, marked empty
      prefetch_valid <= !(redirect || skip); // [RULE_06]
    end
  end

  // program memory address: table access in phase two, fetch otherwise
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pm_addr <= ifp_pkg::PC_RESET;
    end else if (phase_one) begin
      pm_addr <= next_tblrd ? {table_pointer[20:1], 1'b0} : pc; // [RULE_17]
    end else if (phase_two) begin
      pm_addr <= fetch_addr; // [RULE_08]
    end
  end

  // instruction latch and two-word tracking
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ir <= ifp_pkg::IR_RESET;
    end else if (phase_one) begin
      ir <= next_ir; // [RULE_03] [RULE_04]
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      second_due <= 1'b0;
      first_op <= ifp_pkg::op_nop;
      first_lo <= 8'h00;
    end else if (phase_four) begin
      // next word belongs to this one
      second_due <= two_word_first; // [RULE_12] [RULE_13]
      first_op <= op;
      first_lo <= ir[7:0];
    end
  end

  // operand read and destination write
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dm_addr <= 12'h000;
      operand <= 8'h00;
    end else begin
      if (phase_one) begin
        dm_addr <= next_dm_addr;
      end
      if (phase_two && reads_dm) begin
        operand <= i_dm_rdata; // [RULE_07]
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dm_wr <= 1'b0;
      dm_wdata <= 8'h00;
    end else begin
      // registered, so the strobe stands through phase four
      dm_wr <= phase_three && writes_dm; // [RULE_07]
      if (phase_three) begin
        dm_wdata <= is_add_working_to_file ? sum : operand;
      end
    end
  end

  // working register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      working <= 8'h00;
    end else if (phase_four) begin
      // literal loads first, then add kept in working
      if (op == ifp_pkg::op_move_literal_to_working || op == ifp_pkg::op_return_with_literal) begin
        working <= ir[7:0]; // [RULE_16]
      end else if (is_add_working_to_file && !dest_file) begin
        working <= sum;
      end
    end
  end

  // return stack
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sp <= ifp_pkg::SP_RESET;
    end else if (phase_four) begin
      if (sec_call && can_push) begin
        sp <= sp + 5'd1; // [RULE_19]
      end else if (is_ret && sp != ifp_pkg::SP_RESET) begin
        sp <= sp - 5'd1; // [RULE_16]
      end
    end
  end

  // return to the word after the call's second word
  always_ff @(posedge i_clk) begin
    if (phase_four && sec_call && can_push) begin
      stack_mem[sp + 5'd1] <= ret_addr; // [RULE_19]
    end
  end

  // table read: one byte, lane chosen by the pointer's low bit
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      table_data <= 8'h00;
    end else if (phase_two && is_tblrd) begin
      table_data <= table_pointer[0] ? i_pm_data[15:8] :
                    i_pm_data[7:0]; // [RULE_17]
    end
  end

  // table pointer bytes are written through data memory addresses
  genvar g;
  generate
    for (g = 0; g < ifp_pkg::TP_BYTES; g = g + 1) begin : g_tp
      wire hit = dm_wr && phase_four &&
                 (dm_addr == ifp_pkg::ADDR_TABLE_POINTER + 12'(g));
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          table_pointer[g*8 +: 8] <= 8'h00;
        end else if (hit) begin
          table_pointer[g*8 +: 8] <= dm_wdata;
        end
      end
    end
  endgenerate

  assign o_phase = phase;
  assign o_pc = {pc[20:1], 1'b0}; // [RULE_09]
  assign o_pm_addr = pm_addr;
  assign o_pm_rd = phase_four || (phase_two && is_tblrd);
  assign o_dm_addr = dm_addr;
  assign o_dm_rd = phase_two && reads_dm; // [RULE_07]
  assign o_dm_wr = dm_wr;
  assign o_dm_wdata = dm_wdata;
  assign o_instruction_latch = ir;
  assign o_working_register = working;
  assign o_table_data_latch = table_data;
  assign o_stack_pointer = sp;

endmodule
`default_nettype wire

// ---- test/ifp_core_asserts.sv ----
/* Port timing checker of the fetch pipeline core.
   Assumes one clock and a low-active reset; bound to ifp_core. */
`timescale 1ns/1ns
`default_nettype none
module ifp_core_asserts (
  input wire logic i_clk, // core clock
  input wire logic i_reset_n, // async reset
  input wire logic [20:0] o_pm_addr, // fetch address
  input wire logic o_pm_rd, // fetch strobe
  input wire logic [11:0] o_dm_addr, // data address
  input wire logic o_dm_rd, // read strobe
  input wire logic o_dm_wr, // write strobe
  input wire logic [3:0] o_phase, // phases
  input wire logic [20:0] o_pc, // counter
  input wire logic [15:0] o_instruction_latch, // executing word
  input wire logic [7:0] o_working_register, // working reg
  input wire logic [4:0] o_stack_pointer // stack pointer
);
  wire [3:0] rot = {o_phase[2:0], o_phase[3]};
  wire [7:0] lit = o_instruction_latch[7:0];
  wire [7:0] hi = o_instruction_latch[15:8];
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_rot; 1'b1 |=> o_phase == $past(rot); endproperty
  a_rot: assert property (p_rot) else $error("phase order");
  property p_even;
    !o_pc[0] && !(o_pm_rd && o_phase[3] && o_pm_addr[0]);
  endproperty
  a_even: assert property (p_even) else $error("odd");
  property p_step; o_phase[0] |=> o_pc == $past(o_pc) + 21'h2; endproperty
  a_step: assert property (p_step) else $error("step");
  property p_fetch;
    o_phase[3] |-> o_pm_rd && o_pm_addr == o_pc - 21'h2;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch");
  property p_rd; o_dm_rd |-> o_phase[1]; endproperty
  a_rd: assert property (p_rd) else $error("read phase");
  property p_wr; o_dm_wr |-> o_phase[3]; endproperty
  a_wr: assert property (p_wr) else $error("write phase");
  property p_ir; !o_phase[0] |=> $stable(o_instruction_latch); endproperty
  a_ir: assert property (p_ir) else $error("latch moved");
  property p_addr; !o_phase[0] |=> $stable(o_dm_addr); endproperty
  a_addr: assert property (p_addr) else $error("addr moved");
  property p_bub;
    o_phase[1] && (hi == 8'hef || hi == 8'hec) |->
      ##8 o_instruction_latch == 16'h0000;
  endproperty
  a_bub: assert property (p_bub) else $error("no bubble");
  property p_push;
    o_phase[1] && hi == 8'hec && o_stack_pointer != 5'h1f |->
      ##12 o_stack_pointer == $past(o_stack_pointer, 12) + 5'h1;
  endproperty
  a_push: assert property (p_push) else $error("push");
  property p_lit;
    o_phase[1] && hi == 8'h0c |-> ##4 o_working_register == $past(lit, 4);
  endproperty
  a_lit: assert property (p_lit) else $error("literal");
endmodule
bind ifp_core ifp_core_asserts chk_u (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .o_pm_addr(o_pm_addr), .o_pm_rd(o_pm_rd), .o_dm_addr(o_dm_addr),
  .o_dm_rd(o_dm_rd), .o_dm_wr(o_dm_wr), .o_phase(o_phase), .o_pc(o_pc),
  .o_instruction_latch(o_instruction_latch),
  .o_working_register(o_working_register),
  .o_stack_pointer(o_stack_pointer));
`default_nettype wire

// ---- test/ifp_mem_model.sv ----
/* Program and data memory arrays beside the core.
   Assumes combinational reads and data writes on the clock edge. */
`timescale 1ns/1ns
`default_nettype none
module ifp_mem_model (
  input wire logic i_clk, // core clock
  input wire logic [20:0] i_pm_addr, // byte address
  input wire logic i_pm_rd, // fetch strobe
  output logic [15:0] o_pm_data, // program word
  input wire logic [11:0] i_dm_addr, // data address
  input wire logic i_dm_rd, // read strobe
  input wire logic i_dm_wr, // write strobe
  input wire logic [7:0] i_dm_wdata, // write byte
  output logic [7:0] o_dm_rdata // read byte
);
  logic [15:0] pm [0:255];
  logic [7:0] dm [0:4095];
  logic [7:0] junk = 8'h5a;
  // whole word from even byte address; junk when idle
  assign o_pm_data = i_pm_rd ? pm[i_pm_addr[8:1]] : {junk, ~junk};
  assign o_dm_rdata = i_dm_rd ? dm[i_dm_addr] : junk;
  always @(posedge i_clk) begin
    junk <= junk + 8'h3b;
    if (i_dm_wr) begin
      dm[i_dm_addr] <= i_dm_wdata;
    end
  end
endmodule
`default_nettype wire

// ---- test/instruction_fetch_pipeline_test.sv ----
/* Self-checking bench running a short program on ifp_core.
   Assumes the memory model answers in the cycle of the address. */
`timescale 1ns/1ns
`default_nettype none
module instruction_fetch_pipeline_test;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [15:0] pm_data, ir, r3;
  logic [7:0] dm_rdata, wdata, w, tl, r0, r1, r2, woff;
  logic [20:0] pm_addr, pc;
  logic [11:0] dm_addr;
  logic pm_rd, dm_rd, dm_wr;
  logic [3:0] phase;
  logic [4:0] sp;
  int failures = 0;
  int n_checks = 0;
  int seed = 32'hd4a81372;
  // call target at word 48 is a computed jump into four literal returns
  logic [15:0] p1 [0:20] = '{16'hec30, 16'hf000, 16'hc123, 16'hf456,
    16'h6620, 16'hc124, 16'hfabc, 16'hc030, 16'hfff6, 16'hc031, 16'hfff7,
    16'hc031, 16'hfff8, 16'h0008, 16'hd7ff, 16'h0000, 16'h26f9,
    16'h0ca7, 16'h0c3c, 16'h0c5e, 16'h0c81};
  ifp_core dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_pm_data(pm_data),
    .i_dm_rdata(dm_rdata), .o_pm_addr(pm_addr), .o_pm_rd(pm_rd),
    .o_dm_addr(dm_addr), .o_dm_rd(dm_rd), .o_dm_wr(dm_wr),
    .o_dm_wdata(wdata), .o_phase(phase), .o_pc(pc),
    .o_instruction_latch(ir), .o_working_register(w),
    .o_table_data_latch(tl), .o_stack_pointer(sp));
  ifp_mem_model mem_u (.i_clk(i_clk), .i_pm_addr(pm_addr), .i_pm_rd(pm_rd),
    .o_pm_data(pm_data), .i_dm_addr(dm_addr), .i_dm_rd(dm_rd),
    .i_dm_wr(dm_wr), .i_dm_wdata(wdata), .o_dm_rdata(dm_rdata));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  function automatic logic [7:0] sum8(input logic [7:0] a, input logic [7:0] b);
    return a + b;
  endfunction
  task automatic chk(input string nm, input logic [20:0] s, input logic [20:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    for (int k = 0; k < 3; k++) begin
      r0 = 8'($random(seed));
      r1 = 8'($random(seed));
      r2 = 8'($random(seed));
      r3 = 16'($random(seed));
      woff = {5'h00, 2'($random(seed)), 1'b0};
      for (int i = 0; i < 256; i++) mem_u.pm[i] = 16'h0000;
      mem_u.pm[0] = {8'h0f, woff};
      mem_u.pm[1] = 16'h2610;
      mem_u.pm[2] = 16'hef20;
      mem_u.pm[3] = 16'hf000;
      mem_u.pm[4] = 16'h2611;
      for (int i = 0; i < 21; i++) mem_u.pm[32+i] = p1[i];
      mem_u.pm[64] = r3;
      mem_u.dm[12'h010] = r0;
      mem_u.dm[12'h011] = r2;
      mem_u.dm[12'h123] = r1;
      mem_u.dm[12'h124] = ~r1;
      mem_u.dm[12'habc] = r2;
      mem_u.dm[12'h020] = 8'h00;
      mem_u.dm[12'h030] = 8'h81;
      mem_u.dm[12'h031] = 8'h00;
      // fetch address low byte, the base of the jump, as read back while the jump word executes
      mem_u.dm[12'hff9] = 8'h62;
      i_reset_n = 1'b0;
      repeat (12) @(posedge i_clk);
      #1 i_reset_n = 1'b1;
      @(posedge i_clk);
      #1;
      chk("phase", phase, 4'h2);
      chk("first latch", ir, 16'h0000);
      repeat (2) @(posedge i_clk);
      #1;
      chk("fetch addr", pm_addr, 21'h0);
      repeat (2) @(posedge i_clk);
      #1;
      chk("second latch", ir, {8'h0f, woff});
      for (int t = 0; t < 800 && ir !== 16'hd7ff; t++) begin
        @(posedge i_clk);
        #1;
      end
      if (ir !== 16'hd7ff) begin
        failures++;
        break;
      end
      repeat (8) @(posedge i_clk);
      #1;
      chk("sum", mem_u.dm[12'h010], sum8(woff, r0));
      chk("flushed", mem_u.dm[12'h011], r2);
      chk("move", mem_u.dm[12'h456], r1);
      chk("lone word", mem_u.dm[12'habc], r2);
      chk("working", w, p1[17 + woff[2:1]][7:0]);
      chk("stack", sp, 5'h00);
      chk("table", tl, r3[15:8]);
      chk("branch loop", ir, 16'hd7ff);
      chk("counter", pc, 21'h000060);
    end
    close_out();
  end
endmodule
`default_nettype wire
